// file: verilog/fwbfc_ctrl.sv
// fifo watermark, miscellaneous control and bit framing registers
`timescale 1ns/1ps
module fwbfc_ctrl
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstn,
  // host register port
  input  fwbfc_pkg::fwbfc_req_t        host_req,
  output logic [7:0]                   host_rdata,
  output logic                         host_rvalid,
  // fifo storage side
  output fwbfc_pkg::fwbfc_byte_t       fifo_wr,
  output logic                         fifo_rd_req,
  input  wire logic [7:0]              fifo_rd_data,
  output logic                         fifo_flush,
  input  wire logic                    tx_fifo_rd,
  // modem side
  input  wire logic                    transceive_active,
  input  wire logic                    rx_frame_start,
  input  wire logic                    rx_bit_valid,
  input  wire logic                    rx_bit,
  input  wire logic                    rx_frame_end,
  input  wire logic [79:0]             stored_identifier,
  // control outputs
  output logic                         timer_halt_strobe,
  output logic                         timer_launch_strobe,
  output logic                         transmit_trigger,
  output logic                         role_initiator,
  output logic [2:0]                   rx_first_bit_offset,
  output logic [2:0]                   tx_final_byte_bits,
  // status outputs
  output logic                         fifo_nearly_full_flag,
  output logic                         fifo_nearly_empty_flag,
  output logic [6:0]                   buffer_fill_count
);

  fwbfc_pkg::fwbfc_ctrl_st_t st_r;
  fwbfc_pkg::fwbfc_ctrl_st_t st_nxt;
  fwbfc_pkg::fwbfc_byte_t    pk_byte;
  logic [2:0]                pk_last;
  logic                      pk_done;
  logic                      full;
  logic                      rx_fwr;
  logic                      host_fwr;
  logic                      id_fwr;
  logic                      any_rd;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // fill count step; one write and one read in the same cycle cancel
  function automatic logic [6:0] lvl_step(input logic [6:0] l, input logic inc, input logic dec);
    case ({inc, dec})
      2'b10:   return l + 7'h01;
      2'b01:   return l - 7'h01;
      default: return l;
    endcase
  endfunction : lvl_step

  function automatic logic is_wr(input fwbfc_pkg::fwbfc_req_t r, input logic [5:0] a);
    return r.wr && (r.addr == a);
  endfunction : is_wr

  // ----------------------------------------------------------------
  // receive bit packer
  // ----------------------------------------------------------------
  fwbfc_rx_packer u_packer
  (
    .clk         (clk),
    .rstn        (rstn),
    .frame_start (rx_frame_start),
    .bit_valid   (rx_bit_valid),
    .bit_in      (rx_bit),
    .frame_end   (rx_frame_end),
    .align       (st_r.align),
    .byte_o      (pk_byte),
    .last_bits   (pk_last),
    .done        (pk_done)
  );

  // ----------------------------------------------------------------
  // fifo write arbitration and read counting
  // ----------------------------------------------------------------
  // received bytes cannot wait, so they win; the identifier copy fills idle cycles
  assign full     = (st_r.level == fwbfc_pkg::FIFO_DEPTH);
  assign rx_fwr   = pk_byte.valid && !full;
  assign host_fwr = is_wr(host_req, fwbfc_pkg::ADDR_DATA_PORT) && !full && !rx_fwr;
  assign id_fwr   = st_r.copy && !full && !rx_fwr && !host_fwr;
  assign fifo_rd_req = host_req.rd && (host_req.addr == fwbfc_pkg::ADDR_DATA_PORT)
                       && (st_r.level != 7'h00);
  assign any_rd   = fifo_rd_req || (tx_fifo_rd && (st_r.level != 7'h00));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.halt   = 1'b0;
    st_nxt.launch = 1'b0;
    st_nxt.send   = 1'b0;
    st_nxt.flush  = 1'b0;
    st_nxt.rvalid = 1'b0;
    st_nxt.fwr    = 1'b0;
    // identifier copy sequencer, low byte first
    if (id_fwr)
    begin
      st_nxt.fwr   = 1'b1;
      st_nxt.fdata = stored_identifier[{st_r.id_idx, 3'h0} +: fwbfc_pkg::BYTE_W];
      if (st_r.id_idx == fwbfc_pkg::ID_LAST_IDX)
      begin
        st_nxt.copy   = 1'b0;
        st_nxt.id_idx = 4'h0;
      end
      else
        st_nxt.id_idx = st_r.id_idx + 4'h1;
    end
    else if (rx_fwr)
    begin
      st_nxt.fwr   = 1'b1;
      st_nxt.fdata = pk_byte.data;
    end
    else if (host_fwr)
    begin
      st_nxt.fwr   = 1'b1;
      st_nxt.fdata = host_req.wdata;
    end
    // register writes; reserved bits are simply not stored
    if (is_wr(host_req, fwbfc_pkg::ADDR_WARN))
      st_nxt.warn = host_req.wdata[fwbfc_pkg::WARN_W-1:0];
    else if (is_wr(host_req, fwbfc_pkg::ADDR_MISC))
    begin
      st_nxt.halt   = host_req.wdata[fwbfc_pkg::MISC_HALT_BIT];
      st_nxt.launch = host_req.wdata[fwbfc_pkg::MISC_LAUNCH_BIT];
      st_nxt.role   = host_req.wdata[fwbfc_pkg::MISC_ROLE_BIT];
      if (host_req.wdata[fwbfc_pkg::MISC_COPY_BIT])
        st_nxt.copy = 1'b1;
    end
    else if (is_wr(host_req, fwbfc_pkg::ADDR_FRAME))
    begin
      st_nxt.send   = host_req.wdata[fwbfc_pkg::FRAME_SEND_BIT] && transceive_active;
      st_nxt.align  = host_req.wdata[fwbfc_pkg::FRAME_ALIGN_LSB +: fwbfc_pkg::BITCNT_W];
      st_nxt.txbits = host_req.wdata[fwbfc_pkg::BITCNT_W-1:0];
    end
    else if (is_wr(host_req, fwbfc_pkg::ADDR_FILL))
      st_nxt.flush  = host_req.wdata[fwbfc_pkg::FILL_FLUSH_BIT];
    // fill count; a flush empties the buffer outright
    if (st_nxt.flush)
      st_nxt.level = 7'h00;
    else
      st_nxt.level = lvl_step(st_r.level, rx_fwr || host_fwr || id_fwr, any_rd);
    // last received byte bit count
    if (pk_done)
      st_nxt.rxlast = pk_last;
    // alerts track the new count so they never lag the fill register
    st_nxt.hi = ((fwbfc_pkg::FIFO_DEPTH - st_nxt.level) <= {1'b0, st_nxt.warn});
    st_nxt.lo = (st_nxt.level <= {1'b0, st_nxt.warn});
    // read mux; strobes and reserved bits read as zero, unmapped reads zero
    if (host_req.rd)
    begin
      st_nxt.rvalid = 1'b1;
      if (host_req.addr == fwbfc_pkg::ADDR_DATA_PORT)
        st_nxt.rdata = fifo_rd_data;
      else if (host_req.addr == fwbfc_pkg::ADDR_FILL)
        st_nxt.rdata = {1'b0, st_r.level};
      else if (host_req.addr == fwbfc_pkg::ADDR_WARN)
        st_nxt.rdata = {2'b00, st_r.warn};
      else if (host_req.addr == fwbfc_pkg::ADDR_MISC)
        st_nxt.rdata = {2'b00, st_r.copy, st_r.role, 1'b0, st_r.rxlast};
      else if (host_req.addr == fwbfc_pkg::ADDR_FRAME)
        st_nxt.rdata = {1'b0, st_r.align, 1'b0, st_r.txbits};
      else
        st_nxt.rdata = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r        <= '0;
      st_r.warn   <= fwbfc_pkg::WARN_RST;
      st_r.lo     <= 1'b1;
      st_r.hi     <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign host_rdata             = st_r.rdata;
  assign host_rvalid            = st_r.rvalid;
  assign fifo_wr.valid          = st_r.fwr;
  assign fifo_wr.data           = st_r.fdata;
  assign fifo_flush             = st_r.flush;
  assign timer_halt_strobe      = st_r.halt;
  assign timer_launch_strobe    = st_r.launch;
  assign transmit_trigger       = st_r.send;
  assign role_initiator         = st_r.role;
  assign rx_first_bit_offset    = st_r.align;
  assign tx_final_byte_bits     = st_r.txbits;
  assign fifo_nearly_full_flag  = st_r.hi;
  assign fifo_nearly_empty_flag = st_r.lo;
  assign buffer_fill_count      = st_r.level;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // counts identifier bytes pushed during one copy run
  logic [4:0] copy_cnt_r;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      copy_cnt_r <= 5'h00;
    else if (id_fwr)
      copy_cnt_r <= copy_cnt_r + 5'h01;
    else if (!st_r.copy)
      copy_cnt_r <= 5'h00;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  near_full_a: assert property (fifo_nearly_full_flag ==
    ((7'h40 - buffer_fill_count) <= {1'b0, st_r.warn}))
    else $error("nearly-full flag disagrees with free space");
  near_empty_a: assert property (fifo_nearly_empty_flag ==
    (buffer_fill_count <= {1'b0, st_r.warn}))
    else $error("nearly-empty flag disagrees with fill count");
  warn_read_a: assert property ((host_req.rd && host_req.addr == 6'h0B)
    |=> host_rvalid && host_rdata[7:6] == 2'b00)
    else $error("threshold reserved bits not zero");
  // back to back strobe writes are legal, so each pulse is tied to the write just before it
  halt_pulse_a: assert property (timer_halt_strobe == ($past(host_req.wr) &&
    $past(host_req.addr) == fwbfc_pkg::ADDR_MISC && $past(host_req.wdata[7])))
    else $error("halt strobe not a single pulse per write");
  launch_pulse_a: assert property (timer_launch_strobe == ($past(host_req.wr) &&
    $past(host_req.addr) == fwbfc_pkg::ADDR_MISC && $past(host_req.wdata[6])))
    else $error("launch strobe not a single pulse per write");
  copy_count_a: assert property ($fell(st_r.copy) |-> copy_cnt_r == 5'h0A)
    else $error("identifier copy did not push ten bytes");
  role_write_a: assert property ((host_req.wr && host_req.addr == 6'h0C)
    |=> role_initiator == $past(host_req.wdata[4]))
    else $error("role bit not taken from write");
  rx_last_a: assert property (pk_done |=> st_r.rxlast == $past(pk_last))
    else $error("last bit count not captured");
  send_gate_a: assert property (transmit_trigger |->
    $past(transceive_active) && $past(host_req.wr) && $past(host_req.wdata[7])
    && $past(host_req.addr) == fwbfc_pkg::ADDR_FRAME)
    else $error("transmit trigger without active command");
  tx_bits_a: assert property ((host_req.wr && host_req.addr == 6'h0D)
    |=> tx_final_byte_bits == $past(host_req.wdata[2:0]))
    else $error("final byte bit count not taken");
  fill_up_a: assert property ((host_fwr && !any_rd)
    |=> buffer_fill_count == $past(buffer_fill_count) + 7'h01)
    else $error("fill count did not rise on write");

endmodule : fwbfc_ctrl

// file: shared/fwbfc_pkg.sv
// constants, carriers and state records for the fifo watermark / bit framing control block
package fwbfc_pkg;

  // ----------------------------------------------------------------
  // register addresses on the host register port
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_DATA_PORT = 6'h09;
  localparam logic [5:0] ADDR_FILL      = 6'h0A;
  localparam logic [5:0] ADDR_WARN      = 6'h0B;
  localparam logic [5:0] ADDR_MISC      = 6'h0C;
  localparam logic [5:0] ADDR_FRAME     = 6'h0D;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [5:0] WARN_RST       = 6'h08;
  localparam logic [7:0] MISC_RST       = 8'h00;
  localparam logic [7:0] FRAME_RST      = 8'h00;
  localparam int         WARN_W         = 6;
  localparam int         MISC_HALT_BIT  = 7;
  localparam int         MISC_LAUNCH_BIT = 6;
  localparam int         MISC_COPY_BIT  = 5;
  localparam int         MISC_ROLE_BIT  = 4;
  localparam int         FRAME_SEND_BIT = 7;
  localparam int         FRAME_ALIGN_LSB = 4;
  localparam int         FILL_FLUSH_BIT = 7;
  localparam int         BITCNT_W       = 3;

  // ----------------------------------------------------------------
  // buffer and identifier geometry
  // ----------------------------------------------------------------
  localparam int         BYTE_W         = 8;
  localparam int         LEVEL_W        = 7;
  localparam logic [6:0] FIFO_DEPTH     = 7'h40;
  localparam logic [3:0] ID_LAST_IDX    = 4'h9;
  localparam int         ID_W           = 80;
  localparam logic [2:0] LAST_BIT_POS   = 3'h7;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } fwbfc_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } fwbfc_byte_t;

  // control block state
  typedef struct packed {
    logic [5:0] warn;
    logic       role;
    logic       copy;
    logic [3:0] id_idx;
    logic [2:0] align;
    logic [2:0] txbits;
    logic [2:0] rxlast;
    logic [6:0] level;
    logic       halt;
    logic       launch;
    logic       send;
    logic       flush;
    logic       hi;
    logic       lo;
    logic [7:0] rdata;
    logic       rvalid;
    logic       fwr;
    logic [7:0] fdata;
  } fwbfc_ctrl_st_t;

  // receive bit packer state
  typedef struct packed {
    logic [2:0] pos;
    logic [7:0] acc;
    logic       bvalid;
    logic [7:0] bdata;
    logic [2:0] last;
    logic       done;
  } fwbfc_pack_st_t;

endpackage : fwbfc_pkg

// file: verilog/fwbfc_rx_packer.sv
// receive bit packer: places serial bits into bytes from a programmable start position
`timescale 1ns/1ps
module fwbfc_rx_packer
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // bit stream from the receiver
  input  wire logic                 frame_start,
  input  wire logic                 bit_valid,
  input  wire logic                 bit_in,
  input  wire logic                 frame_end,
  input  wire logic [2:0]           align,
  // packed bytes and last byte bit count
  output fwbfc_pkg::fwbfc_byte_t    byte_o,
  output logic [2:0]                last_bits,
  output logic                      done
);

  fwbfc_pkg::fwbfc_pack_st_t st_r;
  fwbfc_pkg::fwbfc_pack_st_t st_nxt;
  logic [2:0]                pos_eff;
  logic [7:0]                acc_eff;

  // ----------------------------------------------------------------
  // packing
  // ----------------------------------------------------------------
  // a frame start re-seeds the position so a stale partial byte never leaks
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.bvalid = 1'b0;
    st_nxt.done   = 1'b0;
    pos_eff       = frame_start ? align : st_r.pos;
    acc_eff       = frame_start ? 8'h00 : st_r.acc;
    if (bit_valid)
    begin
      acc_eff[pos_eff] = bit_in;
      if (pos_eff == fwbfc_pkg::LAST_BIT_POS)
      begin
        st_nxt.bvalid = 1'b1;
        st_nxt.bdata  = acc_eff;
        st_nxt.acc    = 8'h00;
        st_nxt.pos    = 3'h0;
      end
      else
      begin
        st_nxt.acc = acc_eff;
        st_nxt.pos = pos_eff + 3'h1;
      end
    end
    else
    begin
      st_nxt.acc = acc_eff;
      st_nxt.pos = pos_eff;
    end
    // a partial byte is flushed at frame end; zero means a whole byte
    if (frame_end)
    begin
      st_nxt.done = 1'b1;
      st_nxt.last = st_nxt.pos;
      if (st_nxt.pos != 3'h0)
      begin
        st_nxt.bvalid = 1'b1;
        st_nxt.bdata  = st_nxt.acc;
      end
      st_nxt.acc = 8'h00;
      st_nxt.pos = 3'h0;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign byte_o.valid = st_r.bvalid;
  assign byte_o.data  = st_r.bdata;
  assign last_bits    = st_r.last;
  assign done         = st_r.done;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  align_seed_a: assert property (@(posedge clk) disable iff (!rstn)
    (frame_start && bit_valid && !frame_end && align != fwbfc_pkg::LAST_BIT_POS)
      |=> st_r.pos == $past(align) + 3'h1)
    else $error("first bit not stored at the alignment position");
  // covers a wrap on the first bit of a frame too, the alignment-seven case
  wrap_byte_a: assert property (@(posedge clk) disable iff (!rstn)
    (bit_valid && (frame_start ? align == fwbfc_pkg::LAST_BIT_POS
                               : st_r.pos == fwbfc_pkg::LAST_BIT_POS))
      |=> st_r.bvalid && st_r.pos == 3'h0)
    else $error("bit after position seven did not start a new byte");

endmodule : fwbfc_rx_packer

// file: verif/fwbfc_host_model.sv
// host controller model that reaches the control registers over the strobe port
`timescale 1ns/1ps
module fwbfc_host_model
(
  // clock
  input  wire logic             clk,
  // register port
  output fwbfc_pkg::fwbfc_req_t host_req,
  input  wire logic [7:0]       host_rdata,
  input  wire logic             host_rvalid
);
  initial host_req = '0;

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // a gap cycle before each strobe keeps one assignment per time step
  task automatic wr(input logic [5:0] addr, input logic [7:0] data);
    @(posedge clk);
    #1 host_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clk);
    #1 host_req = '0;
  endtask : wr

  // the answer pulse stands one cycle; a missing answer hands back unknowns
  task automatic rd(input logic [5:0] addr, output logic [7:0] data);
    @(posedge clk);
    #1 host_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge clk);
    #1 host_req = '0;
    data = (host_rvalid === 1'b1) ? host_rdata : 8'hXX;
  endtask : rd
endmodule : fwbfc_host_model

// file: verif/fwbfc_ctrl_bench.sv
// self-checking bench for the fifo watermark and bit framing control block
`timescale 1ns/1ps
module fwbfc_ctrl_bench;
  logic clk = 1'b0, rstn = 1'b0, tx_fifo_rd = 1'b0, transceive_active = 1'b0;
  logic rx_frame_start = 1'b0, rx_bit_valid = 1'b0, rx_bit = 1'b0, rx_frame_end = 1'b0;
  logic [79:0] stored_identifier = '0;
  fwbfc_pkg::fwbfc_req_t  host_req;
  fwbfc_pkg::fwbfc_byte_t fifo_wr;
  logic [7:0] host_rdata, fifo_rd_data, rv, wdat [64], mem [64];
  logic host_rvalid, fifo_rd_req, fifo_flush, halt, launch, trig, role, full, empty;
  logic [2:0] align, txbits;
  logic [6:0] fill;
  logic [5:0] wp = '0, rp = '0, thr;
  logic [15:0] bits;
  logic [31:0] seed = 32'hFD08;
  int fails = 0, num_checks = 0, cycles = 0, exp_cnt = 0;

  always #2.5 clk = ~clk;

  fwbfc_host_model u_fwbfc_host_model (.clk(clk), .host_req(host_req),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid));

  fwbfc_ctrl u_fwbfc_ctrl (.clk(clk), .rstn(rstn), .host_req(host_req),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .fifo_wr(fifo_wr),
    .fifo_rd_req(fifo_rd_req), .fifo_rd_data(fifo_rd_data), .fifo_flush(fifo_flush),
    .tx_fifo_rd(tx_fifo_rd), .transceive_active(transceive_active),
    .rx_frame_start(rx_frame_start), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .rx_frame_end(rx_frame_end), .stored_identifier(stored_identifier),
    .timer_halt_strobe(halt), .timer_launch_strobe(launch), .transmit_trigger(trig),
    .role_initiator(role), .rx_first_bit_offset(align), .tx_final_byte_bits(txbits),
    .fifo_nearly_full_flag(full), .fifo_nearly_empty_flag(empty),
    .buffer_fill_count(fill));

  // ----------------------------------------------------------------
  // external buffer storage, head shown fall-through
  // ----------------------------------------------------------------
  assign fifo_rd_data = mem[rp];
  always @(posedge clk)
  begin
    if (fifo_flush)
    begin
      wp <= '0;
      rp <= '0;
    end
    else
    begin
      if (fifo_wr.valid) mem[wp] <= fifo_wr.data;
      if (fifo_wr.valid) wp <= wp + 6'h01;
      if (fifo_rd_req || tx_fifo_rd) rp <= rp + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk

  // count and alerts are judged one edge after the operation settled
  task automatic chk_level();
    @(posedge clk);
    #1 chk("fill count", 8'(exp_cnt), {1'b0, fill});
    chk("nearly full", {7'h00, (64 - exp_cnt) <= int'(thr)}, {7'h00, full});
    chk("nearly empty", {7'h00, exp_cnt <= int'(thr)}, {7'h00, empty});
  endtask : chk_level

  // one received bit per cycle, start and end flags on first and last bit
  task automatic rx_frame(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      #1 rx_frame_start = (i == 0);
      rx_bit_valid = 1'b1;
      rx_bit = bits[i];
      rx_frame_end = (i == n - 1);
    end
    @(posedge clk);
    #1 {rx_frame_start, rx_bit_valid, rx_frame_end} = 3'h0;
    repeat (4) @(posedge clk);
  endtask : rx_frame

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [5:0] ad [4] = '{fwbfc_pkg::ADDR_WARN, fwbfc_pkg::ADDR_MISC,
                           fwbfc_pkg::ADDR_FRAME, 6'h3F};
    logic [7:0] rst_v [4] = '{8'h08, 8'h00, 8'h00, 8'h00};
    logic [7:0] wr_v [4] = '{8'hFF, 8'h1F, 8'h7F, 8'hFF};
    logic [7:0] rb_v [4] = '{8'h3F, 8'h10, 8'h77, 8'h00};
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
    thr = 6'h08;
    chk_level();
    for (int i = 0; i < 4; i++)
    begin
      u_fwbfc_host_model.rd(ad[i], rv);
      chk("reset value", rst_v[i], rv);
      u_fwbfc_host_model.wr(ad[i], wr_v[i]);
      u_fwbfc_host_model.rd(ad[i], rv);
      chk("reserved bits", rb_v[i], rv);
    end
    chk("initiator role", 8'h01, {7'h00, role});
    chk("rx offset", 8'h07, {5'h00, align});
    u_fwbfc_host_model.wr(fwbfc_pkg::ADDR_MISC, 8'hC0);
    chk("halt strobe", 8'h03, {6'h00, halt, launch});
    @(posedge clk);
    #1 chk("strobes end", 8'h00, {5'h00, halt, launch, role});
    u_fwbfc_host_model.rd(fwbfc_pkg::ADDR_MISC, rv);
    chk("strobes read", 8'h00, rv);
    for (int i = 0; i < 2; i++)
    begin
      transceive_active = i[0];
      u_fwbfc_host_model.wr(fwbfc_pkg::ADDR_FRAME, 8'h85);
      chk("transmit trigger", {7'h00, i[0]}, {7'h00, trig});
      chk("final byte bits", 8'h05, {5'h00, txbits});
      u_fwbfc_host_model.rd(fwbfc_pkg::ADDR_FRAME, rv);
      chk("frame read", 8'h05, rv);
    end
    // fill past full with random bytes and a random threshold, then drain
    seed = xs(seed);
    thr = seed[5:0];
    u_fwbfc_host_model.wr(fwbfc_pkg::ADDR_WARN, {2'h0, thr});
    for (int i = 0; i < 66; i++)
    begin
      seed = xs(seed);
      if (i < 64) wdat[i] = seed[7:0];
      u_fwbfc_host_model.wr(fwbfc_pkg::ADDR_DATA_PORT, seed[7:0]);
      if (exp_cnt < 64) exp_cnt++;
      chk_level();
    end
    @(posedge clk);
    #1 tx_fifo_rd = 1'b1;
    @(posedge clk);
    #1 tx_fifo_rd = 1'b0;
    exp_cnt--;
    for (int k = 1; k < 65; k++)
    begin
      u_fwbfc_host_model.rd(fwbfc_pkg::ADDR_DATA_PORT, rv);
      if (k < 64) chk("data port", wdat[k], rv);
      if (exp_cnt > 0) exp_cnt--;
      chk_level();
    end
    // identifier copy, read back in order, then a second copy flushed away
    for (int i = 0; i < 3; i++)
    begin
      seed = xs(seed);
      stored_identifier = {stored_identifier[47:0], seed};
    end
    u_fwbfc_host_model.wr(fwbfc_pkg::ADDR_MISC, 8'h20);
    u_fwbfc_host_model.rd(fwbfc_pkg::ADDR_MISC, rv);
    chk("copy busy", 8'h20, rv);
    repeat (12) @(posedge clk);
    u_fwbfc_host_model.rd(fwbfc_pkg::ADDR_MISC, rv);
    chk("copy cleared", 8'h00, rv);
    exp_cnt = 10;
    chk_level();
    for (int k = 0; k < 10; k++)
    begin
      u_fwbfc_host_model.rd(fwbfc_pkg::ADDR_DATA_PORT, rv);
      chk("identifier byte", stored_identifier[8*k+:8], rv);
    end
    u_fwbfc_host_model.wr(fwbfc_pkg::ADDR_MISC, 8'h20);
    repeat (14) @(posedge clk);
    u_fwbfc_host_model.wr(fwbfc_pkg::ADDR_FILL, 8'h80);
    exp_cnt = 0;
    chk_level();
    // bitwise anticollision frame, the only use of a nonzero offset
    seed = xs(seed);
    bits = seed[15:0];
    u_fwbfc_host_model.wr(fwbfc_pkg::ADDR_FRAME, 8'h70);
    rx_frame(9);
    u_fwbfc_host_model.rd(fwbfc_pkg::ADDR_MISC, rv);
    chk("rx valid bits full", 8'h00, rv & 8'h07);
    u_fwbfc_host_model.rd(fwbfc_pkg::ADDR_DATA_PORT, rv);
    chk("first rx bit at top", {bits[0], 7'h00}, rv & 8'h80);
    u_fwbfc_host_model.rd(fwbfc_pkg::ADDR_DATA_PORT, rv);
    chk("wrapped rx byte", bits[8:1], rv);
    u_fwbfc_host_model.wr(fwbfc_pkg::ADDR_FRAME, 8'h00);
    rx_frame(3);
    u_fwbfc_host_model.rd(fwbfc_pkg::ADDR_MISC, rv);
    chk("rx valid bits partial", 8'h03, rv & 8'h07);
    u_fwbfc_host_model.rd(fwbfc_pkg::ADDR_DATA_PORT, rv);
    chk("partial rx byte", {5'h00, bits[2:0]}, rv & 8'h07);
    chk_level();
    finish_test();
  end
endmodule : fwbfc_ctrl_bench
